// file: rtl/dlh_src_cfg.sv
// Source-side link configuration, hot-plug detect and pixel staging
// What this block does
// - After reset the source runs 640x480, 60 Hz, single pixel, 24 bpp.
// - Source provides all eight data lanes, both clocks and upper pixel lines.
// - Default mode enables only the lower-pixel lanes; upper lanes stay off.
// - Default holds until identification is read and a common mode chosen.
// - Current above 1 mA on the channel power pin raises attach event.
// - Attach event is reported to the host system.
// - After attach the source stays in default until a mode is chosen.
// - Pixels, syncs, enable and two spare controls go to the serializer.
// - Pixel data passes unaltered in 24 bpp modes, low two bits of each colour cleared in 18 bpp; no encipherment on the link.
// - Pixels flow line by line; syncs are forwarded in source order.
// - Dual mode sends both halves with one shared set of syncs.
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps

module dlh_src_cfg
  import dlh_pkg::*;
#(
  parameter int DEB_CYCLES = dlh_pkg::DEB_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Power-pin current comparators
  input  wire logic        ddc_cur_above_1ma,
  input  wire logic        ddc_cur_below_500ua,
  // Host event reporting
  output logic             attach_evt,
  output logic             removal_evt,
  output logic             sink_attached,
  // Parallel pixel input
  input  wire logic [23:0] pix_lo_in,
  input  wire logic [23:0] pix_hi_in,
  input  wire logic        hsync_in,
  input  wire logic        vsync_in,
  input  wire logic        de_in,
  input  wire logic        cntl_e_in,
  input  wire logic        cntl_f_in,
  // Serializer side
  output logic      [23:0] pix_lo_out,
  output logic      [23:0] pix_hi_out,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             de_out,
  output logic             cntl_e_out,
  output logic             cntl_f_out,
  output logic      [7:0]  lane_en,
  output logic             clk1_en,
  output logic             clk2_en,
  // Active mode
  output dlh_pkg::dlh_fmt_t act_fmt,
  output logic      [11:0] act_hres,
  output logic      [11:0] act_vres,
  output logic      [7:0]  act_rate,
  output logic             dflt_active
);

  // ==========================================================
  // Elaboration checks
  if (DEB_CYCLES < 2 || DEB_CYCLES > 1_000_000) begin : g_chk
    $error("DEB_CYCLES out of range");
  end

  localparam int CW = $clog2(DEB_CYCLES + 1);
  localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYCLES - 1);

  // ==========================================================
  // Helpers
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] wmerge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Serial lanes used by a format
  function automatic logic [7:0] lanes_for(input dlh_fmt_t f);
    case (f)
      FMT_18S: lanes_for = 8'h07;
      FMT_24S: lanes_for = 8'h0F;
      FMT_18D: lanes_for = 8'h7F;
      FMT_24D: lanes_for = 8'hFF;
      default: lanes_for = 8'h07;
    endcase
  endfunction : lanes_for

  // Clear the two low bits of each colour in 18 bpp modes
  function automatic logic [23:0] depth_mask(
    input logic [23:0] px,
    input logic        is24
  );
    depth_mask = is24 ? px : (px & 24'hFCFCFC);
  endfunction : depth_mask

  // ==========================================================
  // Comparator synchronisers and debouncers
  logic [2:0]    att_sync_ff;
  logic [2:0]    rem_sync_ff;
  logic          att_deb_ff;
  logic          rem_deb_ff;
  logic [CW-1:0] att_cnt_ff;
  logic [CW-1:0] rem_cnt_ff;

  // Three-stage synchronisers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      att_sync_ff <= 3'h0;
      rem_sync_ff <= 3'h0;
    end else begin
      att_sync_ff <= {att_sync_ff[1:0], ddc_cur_above_1ma};
      rem_sync_ff <= {rem_sync_ff[1:0], ddc_cur_below_500ua};
    end
  end

  // Attach level must stay changed for the debounce time
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      att_cnt_ff <= '0;
      att_deb_ff <= 1'b0;
    end else if (att_sync_ff[2] != att_sync_ff[1] || att_sync_ff[2] == att_deb_ff) begin
      att_cnt_ff <= '0;
    end else if (att_cnt_ff == DEB_LAST) begin
      att_cnt_ff <= '0;
      att_deb_ff <= att_sync_ff[2];
    end else begin
      att_cnt_ff <= att_cnt_ff + CW'(1);
    end
  end

  // Removal level must stay changed for the debounce time
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rem_cnt_ff <= '0;
      rem_deb_ff <= 1'b0;
    end else if (rem_sync_ff[2] != rem_sync_ff[1] || rem_sync_ff[2] == rem_deb_ff) begin
      rem_cnt_ff <= '0;
    end else if (rem_cnt_ff == DEB_LAST) begin
      rem_cnt_ff <= '0;
      rem_deb_ff <= rem_sync_ff[2];
    end else begin
      rem_cnt_ff <= rem_cnt_ff + CW'(1);
    end
  end

  // ==========================================================
  // Hot-plug state
  logic attached_ff;
  logic att_evt_ff;
  logic rem_evt_ff;
  logic nxt_att_evt;
  logic nxt_rem_evt;

  // Attach when debounced current rises, removal when it falls away
  always_comb begin
    nxt_att_evt = !attached_ff && att_deb_ff && !rem_deb_ff;
    nxt_rem_evt = attached_ff && rem_deb_ff;
  end

  // Attached level and one-cycle event pulses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      attached_ff <= 1'b0;
      att_evt_ff  <= 1'b0;
      rem_evt_ff  <= 1'b0;
    end else begin
      att_evt_ff <= nxt_att_evt;
      rem_evt_ff <= nxt_rem_evt;
      if (nxt_att_evt) begin
        attached_ff <= 1'b1;
      end else if (nxt_rem_evt) begin
        attached_ff <= 1'b0;
      end
    end
  end

  assign attach_evt    = att_evt_ff;
  assign removal_evt   = rem_evt_ff;
  assign sink_attached = attached_ff;

  // ==========================================================
  // Register bus
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        wr_take;
  logic        hit_ctrl;
  logic        hit_cfg;
  logic        hit_hres;
  logic        hit_vres;
  logic        hit_rate;
  logic        hit_stat;

  // Every access waits exactly one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign wr_take         = avs_write && ack_ff;

  // Address decode
  always_comb begin
    hit_ctrl = (avs_address == OFS_CTRL);
    hit_cfg  = (avs_address == OFS_CFG);
    hit_hres = (avs_address == OFS_HRES);
    hit_vres = (avs_address == OFS_VRES);
    hit_rate = (avs_address == OFS_RATE);
    hit_stat = (avs_address == OFS_STAT);
  end

  // ==========================================================
  // Pending configuration from software
  logic        edid_ok_ff;
  dlh_fmt_t    req_fmt_ff;
  logic        req_clk2_ff;
  logic [11:0] req_hres_ff;
  logic [11:0] req_vres_ff;
  logic [7:0]  req_rate_ff;
  logic        sti_att_ff;
  logic        sti_rem_ff;
  logic [31:0] ctrl_w;
  logic [31:0] cfg_w;
  logic [31:0] res_w;
  logic [31:0] hres_w;
  logic [31:0] vres_w;
  logic [31:0] rate_w;
  logic        apply_req;
  logic        dflt_req;

  // Merged write values
  always_comb begin
    ctrl_w    = wmerge({29'h0, 2'h0, edid_ok_ff}, avs_writedata, avs_byteenable);
    cfg_w     = wmerge({29'h0, req_clk2_ff, req_fmt_ff}, avs_writedata, avs_byteenable);
    res_w     = wmerge(32'h0, avs_writedata, avs_byteenable);
    hres_w    = wmerge({20'h0, req_hres_ff}, avs_writedata, avs_byteenable);
    vres_w    = wmerge({20'h0, req_vres_ff}, avs_writedata, avs_byteenable);
    rate_w    = wmerge({24'h0, req_rate_ff}, avs_writedata, avs_byteenable);
    apply_req = wr_take && hit_ctrl && ctrl_w[CTRL_APPLY];
    dflt_req  = wr_take && hit_ctrl && ctrl_w[CTRL_DFLT];
  end

  // Identification-read flag; a fresh attach or removal makes it stale
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      edid_ok_ff <= 1'b0;
    end else if (nxt_att_evt || nxt_rem_evt) begin
      edid_ok_ff <= 1'b0;
    end else if (wr_take && hit_ctrl) begin
      edid_ok_ff <= ctrl_w[CTRL_EDID_OK];
    end
  end

  // Requested mode registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_fmt_ff  <= RST_FMT;
      req_clk2_ff <= 1'b0;
      req_hres_ff <= RST_HRES;
      req_vres_ff <= RST_VRES;
      req_rate_ff <= RST_RATE;
    end else if (wr_take) begin
      if (hit_cfg) begin
        req_fmt_ff  <= dlh_fmt_t'(cfg_w[CFG_FMT_LSB +: 2]);
        req_clk2_ff <= cfg_w[CFG_CLK2];
      end
      if (hit_hres) begin
        req_hres_ff <= hres_w[11:0];
      end
      if (hit_vres) begin
        req_vres_ff <= vres_w[11:0];
      end
      if (hit_rate) begin
        req_rate_ff <= rate_w[7:0];
      end
    end
  end

  // Sticky event flags, write one to clear, a new event wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sti_att_ff <= 1'b0;
      sti_rem_ff <= 1'b0;
    end else begin
      if (nxt_att_evt) begin
        sti_att_ff <= 1'b1;
      end else if (wr_take && hit_stat && res_w[ST_ATT_EVT]) begin
        sti_att_ff <= 1'b0;
      end
      if (nxt_rem_evt) begin
        sti_rem_ff <= 1'b1;
      end else if (wr_take && hit_stat && res_w[ST_REM_EVT]) begin
        sti_rem_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Active configuration
  dlh_fmt_t    act_fmt_ff;
  logic        act_clk2_ff;
  logic [11:0] act_hres_ff;
  logic [11:0] act_vres_ff;
  logic [7:0]  act_rate_ff;
  logic        dflt_ff;

  // Default until identification is read and a mode applied
  always_ff @(posedge ref_clk) begin
    if (reset || nxt_att_evt || nxt_rem_evt || dflt_req) begin
      act_fmt_ff  <= RST_FMT;
      act_clk2_ff <= 1'b0;
      act_hres_ff <= RST_HRES;
      act_vres_ff <= RST_VRES;
      act_rate_ff <= RST_RATE;
      dflt_ff     <= 1'b1;
    end else if (apply_req && edid_ok_ff && attached_ff) begin
      act_fmt_ff  <= req_fmt_ff;
      act_clk2_ff <= req_clk2_ff;
      act_hres_ff <= req_hres_ff;
      act_vres_ff <= req_vres_ff;
      act_rate_ff <= req_rate_ff;
      dflt_ff     <= 1'b0;
    end
  end

  assign act_fmt     = act_fmt_ff;
  assign act_hres    = act_hres_ff;
  assign act_vres    = act_vres_ff;
  assign act_rate    = act_rate_ff;
  assign dflt_active = dflt_ff;

  // ==========================================================
  // Read data, captured while waitrequest is high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_ff <= 32'h0;
    end else if (avs_read && !ack_ff) begin
      case (1'b1)
        hit_ctrl: rdata_ff <= {31'h0, edid_ok_ff};
        hit_cfg:  rdata_ff <= {29'h0, req_clk2_ff, req_fmt_ff};
        hit_hres: rdata_ff <= {20'h0, req_hres_ff};
        hit_vres: rdata_ff <= {20'h0, req_vres_ff};
        hit_rate: rdata_ff <= {24'h0, req_rate_ff};
        hit_stat: rdata_ff <= {25'h0, edid_ok_ff, act_fmt_ff, dflt_ff,
                               sti_rem_ff, sti_att_ff, attached_ff};
        default:  rdata_ff <= 32'h0;
      endcase
    end
  end

  assign avs_readdata = rdata_ff;

  // ==========================================================
  // Pixel staging toward the serializer
  logic        dual;
  logic        is24;
  logic [23:0] pix_lo_ff;
  logic [23:0] pix_hi_ff;
  logic [4:0]  ctl_ff;
  logic [7:0]  lane_ff;
  logic        clk2_ff;

  // Mode decode
  always_comb begin
    dual = (act_fmt_ff == FMT_18D) || (act_fmt_ff == FMT_24D);
    is24 = (act_fmt_ff == FMT_24S) || (act_fmt_ff == FMT_24D);
  end

  // Pixels pass in arrival order, not enciphered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pix_lo_ff <= 24'h0;
      pix_hi_ff <= 24'h0;
      ctl_ff    <= 5'h0;
    end else begin
      pix_lo_ff <= depth_mask(pix_lo_in, is24);
      pix_hi_ff <= dual ? depth_mask(pix_hi_in, is24) : 24'h0;
      ctl_ff    <= {cntl_f_in, cntl_e_in, de_in, vsync_in, hsync_in};
    end
  end

  // Lane and clock enables follow the active format
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lane_ff <= 8'h0;
      clk2_ff <= 1'b0;
    end else begin
      lane_ff <= lanes_for(act_fmt_ff);
      clk2_ff <= dual || act_clk2_ff;
    end
  end

  assign pix_lo_out = pix_lo_ff;
  assign pix_hi_out = pix_hi_ff;
  assign hsync_out  = ctl_ff[0];
  assign vsync_out  = ctl_ff[1];
  assign de_out     = ctl_ff[2];
  assign cntl_e_out = ctl_ff[3];
  assign cntl_f_out = ctl_ff[4];
  assign lane_en    = lane_ff;
  assign clk1_en    = 1'b1;
  assign clk2_en    = clk2_ff;

endmodule : dlh_src_cfg

// file: rtl/dlh_pkg.sv
// Shared constants for the display link config and hot-plug block
package dlh_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CFG  = 5'h04;
  localparam logic [4:0] OFS_HRES = 5'h08;
  localparam logic [4:0] OFS_VRES = 5'h0C;
  localparam logic [4:0] OFS_RATE = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_EDID_OK = 0;
  localparam int CTRL_APPLY   = 1;
  localparam int CTRL_DFLT    = 2;
  localparam int CFG_FMT_LSB  = 0;
  localparam int CFG_CLK2     = 2;
  localparam int ST_ATT       = 0;
  localparam int ST_ATT_EVT   = 1;
  localparam int ST_REM_EVT   = 2;
  localparam int ST_DFLT      = 3;
  localparam int ST_FMT_LSB   = 4;
  localparam int ST_EDID_OK   = 6;

  // ==========================================================
  // Pixel formats
  typedef enum logic [1:0] {
    FMT_18S = 2'h0,
    FMT_24S = 2'h1,
    FMT_18D = 2'h2,
    FMT_24D = 2'h3
  } dlh_fmt_t;

  // ==========================================================
  // Values after reset: 640x480, 60 Hz, single pixel, 24 bpp
  localparam dlh_fmt_t    RST_FMT  = FMT_24S;
  localparam logic [11:0] RST_HRES = 12'h280;
  localparam logic [11:0] RST_VRES = 12'h1E0;
  localparam logic [7:0]  RST_RATE = 8'h3C;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int DEB_TIME_US  = 1000;
  localparam int DEB_CYC      = (CLK_HZ / 1_000_000) * DEB_TIME_US;

endpackage : dlh_pkg

// file: dv/dlh_sink_model.sv
// Display-side model drawing load current on the channel power pin
`timescale 1ns/10ps
module dlh_sink_model #(
  parameter bit RX24 = 1'b0
) (
  // Connection state commanded by the bench
  input  wire logic        plugged,
  // Link from the source
  input  wire logic [23:0] pix_lo_out,
  input  wire logic [7:0]  lane_en,
  input  wire logic        dflt_active,
  // Comparator levels seen by the source
  output logic             ddc_cur_above_1ma,
  output logic             ddc_cur_below_500ua,
  // Receive side state
  output logic      [23:0] rx_pix,
  output logic             rx_lanes_ok,
  output logic             rx_dflt,
  output logic             rx_id_ready,
  output logic             rx_standby
);
  // ==========
  // Load current
  // Attached display draws over 1 mA, a detached one draws nothing
  assign ddc_cur_above_1ma   = plugged;
  assign ddc_cur_below_500ua = !plugged;
  // ==========
  // Default receive path
  // Lower lanes only, 18 bpp unless the 24 bpp default is chosen
  assign rx_pix      = RX24 ? pix_lo_out : (pix_lo_out & 24'hFCFCFC);
  // Only the three lanes of the narrowest format are fitted
  assign rx_lanes_ok = &lane_en[2:0];
  // Stays default until the source leaves it after the id read
  assign rx_dflt     = dflt_active || !plugged;
  // Id data answers as soon as the cable is in
  assign rx_id_ready = plugged;
  // Blank and stand by while no source activity is seen
  assign rx_standby  = !plugged || !lane_en[0];
endmodule : dlh_sink_model

// file: dv/dlh_src_cfg_assertions.sv
// Concurrent checks on the source link config block
`timescale 1ns/10ps
module dlh_src_cfg_assertions
  import dlh_pkg::*;
#(
  parameter int DEB_CYCLES = 8
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // Register bus
  input wire logic [4:0]        avs_address,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  // Hot plug
  input wire logic              ddc_cur_above_1ma,
  input wire logic              attach_evt,
  input wire logic              sink_attached,
  // Link and mode
  input wire logic [23:0]       pix_lo_in,
  input wire logic [23:0]       pix_lo_out,
  input wire logic [23:0]       pix_hi_out,
  input wire logic [7:0]        lane_en,
  input wire dlh_pkg::dlh_fmt_t act_fmt,
  input wire logic [11:0]       act_hres,
  input wire logic [11:0]       act_vres,
  input wire logic [7:0]        act_rate,
  input wire logic              dflt_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========
  // Helper logic
  logic        apply_req;
  logic [15:0] hi_cnt_ff;
  // Apply write at its taking edge
  assign apply_req = avs_write && !avs_waitrequest && avs_address == OFS_CTRL
                     && avs_byteenable[0] && avs_writedata[CTRL_APPLY];
  // Cycles the attach comparator has stayed high
  always_ff @(posedge ref_clk) begin
    if (reset || !ddc_cur_above_1ma) hi_cnt_ff <= 16'h0000;
    else if (hi_cnt_ff != 16'hFFFF) hi_cnt_ff <= hi_cnt_ff + 16'h0001;
  end

  // ==========
  // Assertions
  chk_dflt_mode: assert property (dflt_active |-> act_fmt == FMT_24S && act_hres == 12'h280
    && act_vres == 12'h1E0 && act_rate == 8'h3C) else $error("default mode values wrong");
  chk_lane_dflt: assert property (!$past(reset) && $past(dflt_active) |-> lane_en == 8'h0F)
    else $error("default lanes wrong");
  chk_hi_zero: assert property ($past(dflt_active) |-> pix_hi_out == 24'h000000)
    else $error("upper pixel driven in default");
  chk_pix_pass: assert property (!$past(reset) && $past(dflt_active) |-> pix_lo_out == $past(pix_lo_in))
    else $error("pixel data altered");
  chk_att_pulse: assert property ($rose(sink_attached) |-> attach_evt ##1 !attach_evt)
    else $error("attach event pulse wrong");
  chk_att_dflt: assert property ($rose(sink_attached) |-> dflt_active)
    else $error("attach left non-default mode");
  chk_deb_hold: assert property ($rose(sink_attached) |-> hi_cnt_ff >= DEB_CYCLES)
    else $error("attach before debounce span");
  chk_apply_gate: assert property ($fell(dflt_active) |-> $past(apply_req) && $past(sink_attached))
    else $error("default left without apply");

  // ==========
  // Coverage
  cov_attach: cover property ($rose(sink_attached));
  cov_apply: cover property ($fell(dflt_active));
  cov_dual: cover property (lane_en == 8'hFF);
endmodule : dlh_src_cfg_assertions

bind dlh_src_cfg dlh_src_cfg_assertions #(.DEB_CYCLES(DEB_CYCLES)) u_chk (
  .ref_clk, .reset, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .ddc_cur_above_1ma, .attach_evt, .sink_attached, .pix_lo_in,
  .pix_lo_out, .pix_hi_out, .lane_en, .act_fmt, .act_hres, .act_vres, .act_rate, .dflt_active
);

// file: dv/tb_dlh_src_cfg.sv
// Self-checking bench for the source link config block
`timescale 1ns/10ps
module tb_dlh_src_cfg;
  import dlh_pkg::*;
  localparam int DEB = 8;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        plugged = 1'b0;
  logic        ddc_cur_above_1ma, ddc_cur_below_500ua;
  logic [4:0]  avs_address = 5'h00;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [23:0] rx_pix;
  logic        rx_lanes_ok, rx_dflt, rx_id_ready, rx_standby;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, attach_evt, removal_evt, sink_attached, clk1_en, clk2_en, dflt_active;
  logic [23:0] pix_lo_in = 24'h0, pix_hi_in = 24'h0, pix_lo_out, pix_hi_out;
  logic [4:0]  ctl_in = 5'h00, ctl_out;
  logic [7:0]  lane_en, act_rate;
  logic [11:0] act_hres, act_vres;
  dlh_fmt_t    act_fmt;
  logic [15:0] lfsr = 16'h0019;
  int          err_count = 0, samples_checked = 0;

  // Clock generation
  always #20 ref_clk = ~ref_clk;

  // ==========
  // Design and display model
  dlh_src_cfg #(.DEB_CYCLES(DEB)) dut (
    .ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .ddc_cur_above_1ma, .ddc_cur_below_500ua, .attach_evt,
    .removal_evt, .sink_attached, .pix_lo_in, .pix_hi_in, .hsync_in(ctl_in[4]), .vsync_in(ctl_in[3]),
    .de_in(ctl_in[2]), .cntl_e_in(ctl_in[1]), .cntl_f_in(ctl_in[0]), .pix_lo_out, .pix_hi_out,
    .hsync_out(ctl_out[4]), .vsync_out(ctl_out[3]), .de_out(ctl_out[2]), .cntl_e_out(ctl_out[1]),
    .cntl_f_out(ctl_out[0]), .lane_en, .clk1_en, .clk2_en, .act_fmt, .act_hres, .act_vres,
    .act_rate, .dflt_active
  );
  dlh_sink_model u_sink (
    .plugged, .pix_lo_out, .lane_en, .dflt_active, .ddc_cur_above_1ma, .ddc_cur_below_500ua,
    .rx_pix, .rx_lanes_ok, .rx_dflt, .rx_id_ready, .rx_standby
  );

  // ==========
  // Expectation helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    lfsr_next = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next
  function automatic logic [23:0] exp_pix(input logic [23:0] px, input logic [1:0] f, input logic hi);
    exp_pix = (hi && !f[1]) ? 24'h000000 : (f[0] ? px : px & 24'hFCFCFC);
  endfunction : exp_pix
  function automatic logic [7:0] exp_lanes(input logic [1:0] f);
    exp_lanes = f[1] ? (f[0] ? 8'hFF : 8'h7F) : (f[0] ? 8'h0F : 8'h07);
  endfunction : exp_lanes

  // ==========
  // Bench tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Random pixels and controls, each output checked one cycle later
  task automatic pix_run(input int n, input logic [1:0] f);
    logic [23:0] lo, hi;
    logic [4:0]  c;
    repeat (n) begin
      lo = pix_lo_in;
      hi = pix_hi_in;
      c = ctl_in;
      @(posedge ref_clk);
      lfsr = lfsr_next(lfsr);
      pix_lo_in <= {lfsr, lfsr[15:8]};
      pix_hi_in <= {lfsr[7:0], lfsr};
      ctl_in <= lfsr[4:0];
      @(negedge ref_clk);
      check(pix_lo_out, exp_pix(lo, f, 1'b0));
      check(pix_hi_out, exp_pix(hi, f, 1'b1));
      check(rx_pix, exp_pix(lo, 2'h0, 1'b0));
      check(ctl_out, c);
    end
  endtask : pix_run
  // Bounded wait for an attach or removal pulse
  task automatic wait_evt(input logic rem);
    int n;
    n = 0;
    while ((rem ? removal_evt : attach_evt) !== 1'b1 && n < 4 * DEB) begin
      @(negedge ref_clk);
      n++;
    end
    check(rem ? removal_evt : attach_evt, 1'b1);
  endtask : wait_evt
  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ==========
  // Watchdog against a hung wait
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end

  // ==========
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check(act_fmt, FMT_24S);
    check({act_hres, act_vres, act_rate}, {RST_HRES, RST_VRES, RST_RATE});
    check({lane_en, clk1_en, clk2_en, dflt_active}, {8'h0F, 3'b101});
    check({rx_standby, rx_id_ready, rx_lanes_ok}, 3'b101);
    bus(1'b0, OFS_STAT, 32'h0);
    check(rd, 32'h18);
    bus(1'b0, 5'h18, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, OFS_CFG, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h3);
    @(negedge ref_clk);
    check(dflt_active, 1'b1);
    // Short bounce on the comparator
    @(posedge ref_clk);
    plugged <= 1'b1;
    repeat (DEB / 2) @(posedge ref_clk);
    plugged <= 1'b0;
    repeat (4 * DEB) @(negedge ref_clk);
    check(sink_attached, 1'b0);
    @(posedge ref_clk);
    plugged <= 1'b1;
    wait_evt(1'b0);
    check({sink_attached, dflt_active}, 2'b11);
    check({rx_dflt, rx_id_ready, rx_standby}, 3'b110);
    bus(1'b0, OFS_STAT, 32'h0);
    check(rd, 32'h1B);
    bus(1'b1, OFS_STAT, 32'h2);
    bus(1'b0, OFS_STAT, 32'h0);
    check(rd, 32'h19);
    pix_run(12, 2'h1);
    bus(1'b1, OFS_CTRL, 32'h2);
    @(negedge ref_clk);
    check(dflt_active, 1'b1);
    // Mark identification read, then pending resolution, one write on a single byte lane
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_VRES, 32'h258);
    bus(1'b1, OFS_RATE, 32'h4B);
    avs_byteenable <= 4'h2;
    bus(1'b1, OFS_HRES, 32'hFFFF03FF);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_HRES, 32'h0);
    check(rd, 32'h380);
    // Every format, the first with the second clock requested
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, OFS_CFG, 32'(f) | (32'(f == 0) << CFG_CLK2));
      bus(1'b1, OFS_CTRL, 32'h3);
      repeat (2) @(negedge ref_clk);
      check({act_fmt, lane_en, clk2_en, dflt_active, rx_dflt},
            {f[1:0], exp_lanes(f[1:0]), (f[1] || f == 0), 1'b0, 1'b0});
      pix_run(6, f[1:0]);
    end
    check({act_hres, act_vres, act_rate}, {12'h380, 12'h258, 8'h4B});
    bus(1'b1, OFS_CTRL, 32'h4);
    repeat (2) @(negedge ref_clk);
    check({act_fmt, lane_en, dflt_active}, {FMT_24S, 8'h0F, 1'b1});
    check({act_hres, act_vres, act_rate}, {RST_HRES, RST_VRES, RST_RATE});
    @(posedge ref_clk);
    plugged <= 1'b0;
    wait_evt(1'b1);
    check({sink_attached, dflt_active}, 2'b01);
    check(rx_standby, 1'b1);
    tally_and_finish();
  end
endmodule : tb_dlh_src_cfg
